// ---- shared/sltp_defs.vh ----
/*
 Constants for the serial link test pattern generator: register byte
 offsets, field positions, reset values, pattern codes and PN seeds.
 Assumes it is included by its bare name from the design files.
*/
`ifndef SLTP_DEFS_VH
`define SLTP_DEFS_VH

// register byte offsets
`define SLTP_OFF_SOFT_RESET 12'h000
`define SLTP_OFF_USER_FIRST 12'h551
`define SLTP_OFF_USER_LAST 12'h558
`define SLTP_OFF_LINK_CTRL_A 12'h571
`define SLTP_OFF_LINK_CTRL_B 12'h572
`define SLTP_OFF_IF_TEST 12'h573
`define SLTP_OFF_LL_TEST 12'h574

// soft reset command and sync-disable value
`define SLTP_SOFT_RESET_CMD 8'h81
`define SLTP_SYNC_OFF_VALUE 8'hc0

// reset values
`define SLTP_RST_LINK_CTRL_A 8'h00
`define SLTP_RST_LINK_CTRL_B 8'h00
`define SLTP_RST_IF_TEST 8'h00
`define SLTP_RST_LL_TEST 8'h00
`define SLTP_RST_USER 8'h00

// field positions
`define SLTP_TPL_TEST_BIT 5
`define SLTP_IF_MODE_MSB 3
`define SLTP_IF_MODE_LSB 0
`define SLTP_IF_POINT_MSB 5
`define SLTP_IF_POINT_LSB 4
`define SLTP_LL_MODE_MSB 2
`define SLTP_LL_MODE_LSB 0

// interface pattern codes
`define SLTP_MODE_OFF 4'h0
`define SLTP_MODE_CHECKER 4'h1
`define SLTP_MODE_TOGGLE 4'h2
`define SLTP_MODE_PN31 4'h3
`define SLTP_MODE_PN23 4'h4
`define SLTP_MODE_PN15 4'h5
`define SLTP_MODE_PN9 4'h6
`define SLTP_MODE_PN7 4'h7
`define SLTP_MODE_RAMP 4'h8
`define SLTP_MODE_USER_REPEAT 4'he
`define SLTP_MODE_USER_SINGLE 4'hf

// insertion points
`define SLTP_POINT_SAMPLE 2'h0
`define SLTP_POINT_PHY10 2'h1
`define SLTP_POINT_SCRAM8 2'h2

// word widths at each insertion point
`define SLTP_WIDTH_SAMPLE 5'h10
`define SLTP_WIDTH_PHY10 5'h0a
`define SLTP_WIDTH_SCRAM8 5'h08

// checkerboard halves at full width
`define SLTP_CHECK_EVEN 16'h5555
`define SLTP_CHECK_ODD 16'haaaa

// pn seeds
`define SLTP_SEED_PN31 31'h0003afff
`define SLTP_SEED_PN23 31'h00003aff
`define SLTP_SEED_PN15 31'h000003af
`define SLTP_SEED_PN9 31'h00000092
`define SLTP_SEED_PN7 31'h00000007

`endif

// ---- hw/sltp_pn.v ----
/*
 PN sequence generator for the interface test patterns; emits one word of
 8, 10 or 16 bits per step, first generated bit in the word's MSB.
 Assumes the parent pulses load whenever the mode or width changes.
*/
`timescale 1ns/100ps
`include "sltp_defs.vh"

module sltp_pn (
	input wire clk,
	input wire srst,
	input wire load,
	input wire step,
	input wire [3:0] mode,
	input wire [4:0] nbits,
	output reg [15:0] word
);

	reg [30:0] state;
	reg [30:0] seed;
	reg [30:0] next_state;
	reg [30:0] s;
	reg b;
	integer n;
	integer k;
	integer i;

	// polynomial taps and seed per mode
	always @* begin
		case (mode)
			`SLTP_MODE_PN31: begin
				n = 31; k = 28; seed = `SLTP_SEED_PN31;
			end
			`SLTP_MODE_PN23: begin
				n = 23; k = 18; seed = `SLTP_SEED_PN23;
			end
			`SLTP_MODE_PN15: begin
				n = 15; k = 14; seed = `SLTP_SEED_PN15;
			end
			`SLTP_MODE_PN9: begin
				n = 9; k = 5; seed = `SLTP_SEED_PN9;
			end
			default: begin
				n = 7; k = 6; seed = `SLTP_SEED_PN7;
			end
		endcase
	end

	// run the lfsr nbits times for the current word
	always @* begin
		s = state;
		b = 1'b0;
		word = 16'h0000;
		for (i = 0; i < 16; i = i + 1) begin
			if (i < nbits) begin
				b = s[n-1] ^ s[k-1];
				s = {s[29:0], b};
				word = {word[14:0], b};
			end
		end
		next_state = s;
	end

	// state register, reloaded with the seed on restart
	always @(posedge clk) begin
		if (srst) begin
			state <= `SLTP_SEED_PN7;
		end else if (load) begin
			state <= seed;
		end else if (step) begin
			state <= next_state;
		end
	end

endmodule // sltp_pn

// ---- hw/sltp_buf.v ----
/*
 Two-entry buffer with valid/ready on both sides; a stall on the drain
 side fills it and drops in_ready so no word is lost.
 Assumes one clock and a synchronous reset.
*/
`timescale 1ns/100ps

module sltp_buf #(
	parameter WIDTH = 66,
	parameter DEPTH = 2
) (
	input wire clk,
	input wire srst,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output reg [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg wptr;
	reg rptr;
	reg [1:0] count;
	wire push;
	wire pop;

	// handshake terms from the fill level
	assign in_ready = (count != DEPTH);
	assign out_valid = (count != 2'h0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// head word presented from storage flops
	always @* begin
		out_data = mem[rptr];
	end

	// pointers and fill level
	always @(posedge clk) begin
		if (srst) begin
			wptr <= 1'b0;
			rptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push) begin
				mem[wptr] <= in_data;
				wptr <= ~wptr;
			end
			if (pop) begin
				rptr <= ~rptr;
			end
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

endmodule // sltp_buf

// ---- hw/sltp_gen.v ----
/*
 Test pattern generator in the serial output path: holds the link test
 registers, builds interface patterns at the chosen insertion width and
 feeds them, or the raw samples, through a two-entry buffer.
 Assumes a byte register port from the serial control logic and a link
 layer downstream that honours OUT_READY and the link test mode output.
*/
`timescale 1ns/100ps
`include "sltp_defs.vh"

// What this block does
// - The sample test bit of link control A only drives TPL_SAMPLE_TEST; the output carries the raw converter samples whenever no interface pattern is on.
// - The low four bits of the interface test register pick off, checkerboard, toggle, five PN codes, ramp or user.
// - Bits 5:4 of the interface test register pick the sample, 10-bit or 8-bit insertion point.
// - The low three bits of the link layer test register select the link layer test and are passed on.
// - PN31 uses x^31+x^28+1 seeded 0x0003afff and PN23 uses x^23+x^18+1 seeded 0x003aff.
// - PN15, PN9 and PN7 use their trinomials with seeds 0x03af, 0x092 and 0x07.
// - Checkerboard and toggle alternate complementary words cut to the insertion width.
// - The ramp steps by one and wraps at the insertion width.
// - Repeat user mode cycles user words one to four without end.
// - Single user mode sends user words one to four once and then zeros.
// - User words are cut to bits 15:0, 15:6 or 15:9 by insertion point.
// - At sample insertion all four samples of a frame carry the same word, advancing per frame.
module sltp_gen (
	input wire CLOCK,
	input wire SRST,
	input wire REG_WRITE,
	input wire [11:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	output reg [7:0] REG_RDATA,
	input wire [63:0] SAMPLE_DATA,
	input wire SAMPLE_VALID,
	output wire SAMPLE_READY,
	output wire [63:0] OUT_DATA,
	output wire [1:0] OUT_POINT,
	output wire OUT_VALID,
	input wire OUT_READY,
	output reg TPL_SAMPLE_TEST,
	output reg [2:0] LINK_TEST_MODE,
	output reg LINK_SYNC_REQUEST_INPUT_OFF
);

	// register file
	reg [7:0] link_control_a;
	reg [7:0] link_control_b;
	reg [7:0] interface_test_select;
	reg [7:0] link_layer_test_select;
	reg [7:0] user_pattern_byte [0:7];
	wire [11:0] user_index_full;
	wire [2:0] user_index;
	wire user_hit;
	wire soft_reset;
	wire cfg_write;
	integer j;

	// pattern state
	wire [3:0] mode;
	wire [1:0] point;
	wire active;
	wire [4:0] nbits;
	wire [15:0] mask;
	reg phase;
	reg [15:0] ramp;
	reg [1:0] user_sel;
	reg single_done;
	reg restart;
	reg [15:0] pattern_word;
	wire [15:0] pn_word;
	wire [15:0] user_word;
	wire is_pn;
	wire step;

	// buffer path
	reg [63:0] fill_data;
	wire fill_valid;
	wire fill_ready;
	wire [65:0] drain_word;

	// width of one pattern word at an insertion point
	function [4:0] point_width;
		input [1:0] p;
		begin
			case (p)
				`SLTP_POINT_PHY10: point_width = `SLTP_WIDTH_PHY10;
				`SLTP_POINT_SCRAM8: point_width = `SLTP_WIDTH_SCRAM8;
				default: point_width = `SLTP_WIDTH_SAMPLE;
			endcase
		end
	endfunction

	// mask that keeps the low bits of a given width
	function [15:0] width_mask;
		input [4:0] w;
		begin
			width_mask = (w >= 5'h10) ? 16'hffff : ((16'h0001 << w) - 16'h0001);
		end
	endfunction

	// cut a user word to the insertion width
	function [15:0] user_cut;
		input [15:0] u;
		input [1:0] p;
		begin
			case (p)
				`SLTP_POINT_PHY10: user_cut = {6'h00, u[15:6]};
				`SLTP_POINT_SCRAM8: user_cut = {9'h000, u[15:9]};
				default: user_cut = u;
			endcase
		end
	endfunction

	// address decode for the register port
	assign user_index_full = REG_ADDR - `SLTP_OFF_USER_FIRST;
	assign user_index = user_index_full[2:0];
	assign user_hit = (REG_ADDR >= `SLTP_OFF_USER_FIRST) && (REG_ADDR <= `SLTP_OFF_USER_LAST);
	assign soft_reset = REG_WRITE && (REG_ADDR == `SLTP_OFF_SOFT_RESET) && (REG_WDATA == `SLTP_SOFT_RESET_CMD);
	assign cfg_write = REG_WRITE && (REG_ADDR == `SLTP_OFF_IF_TEST);

	// register writes; soft reset restores defaults and leaves nothing stored
	always @(posedge CLOCK) begin
		if (SRST || soft_reset) begin
			link_control_a <= `SLTP_RST_LINK_CTRL_A;
			link_control_b <= `SLTP_RST_LINK_CTRL_B;
			interface_test_select <= `SLTP_RST_IF_TEST;
			link_layer_test_select <= `SLTP_RST_LL_TEST;
			for (j = 0; j < 8; j = j + 1) begin
				user_pattern_byte[j] <= `SLTP_RST_USER;
			end
		end else if (REG_WRITE) begin
			if (REG_ADDR == `SLTP_OFF_LINK_CTRL_A) begin
				link_control_a <= REG_WDATA;
			end
			if (REG_ADDR == `SLTP_OFF_LINK_CTRL_B) begin
				link_control_b <= REG_WDATA;
			end
			if (cfg_write) begin
				interface_test_select <= {2'h0, REG_WDATA[5:0]};
			end
			if (REG_ADDR == `SLTP_OFF_LL_TEST) begin
				link_layer_test_select <= {5'h00, REG_WDATA[2:0]};
			end
			if (user_hit) begin
				user_pattern_byte[user_index] <= REG_WDATA;
			end
		end
	end

	// read mux, registered; unmapped bytes and the soft reset byte read zero
	always @(posedge CLOCK) begin
		if (SRST) begin
			REG_RDATA <= 8'h00;
		end else if (user_hit) begin
			REG_RDATA <= user_pattern_byte[user_index];
		end else begin
			case (REG_ADDR)
				`SLTP_OFF_LINK_CTRL_A: REG_RDATA <= link_control_a;
				`SLTP_OFF_LINK_CTRL_B: REG_RDATA <= link_control_b;
				`SLTP_OFF_IF_TEST: REG_RDATA <= interface_test_select;
				`SLTP_OFF_LL_TEST: REG_RDATA <= link_layer_test_select;
				default: REG_RDATA <= 8'h00;
			endcase
		end
	end

	// control outputs toward the link layer
	always @(posedge CLOCK) begin
		if (SRST) begin
			TPL_SAMPLE_TEST <= 1'b0;
			LINK_TEST_MODE <= 3'h0;
			LINK_SYNC_REQUEST_INPUT_OFF <= 1'b0;
		end else begin
			TPL_SAMPLE_TEST <= link_control_a[`SLTP_TPL_TEST_BIT];
			LINK_TEST_MODE <= link_layer_test_select[`SLTP_LL_MODE_MSB:`SLTP_LL_MODE_LSB];
			LINK_SYNC_REQUEST_INPUT_OFF <= (link_control_b == `SLTP_SYNC_OFF_VALUE);
		end
	end

	// mode, insertion point and width decode
	assign mode = interface_test_select[`SLTP_IF_MODE_MSB:`SLTP_IF_MODE_LSB];
	assign point = interface_test_select[`SLTP_IF_POINT_MSB:`SLTP_IF_POINT_LSB];
	assign active = (mode != `SLTP_MODE_OFF);
	assign nbits = point_width(point);
	assign mask = width_mask(nbits);
	assign is_pn = (mode >= `SLTP_MODE_PN31) && (mode <= `SLTP_MODE_PN7);
	assign step = active && fill_ready && !restart;

	// user word for the current position, two bytes per word, low byte first
	assign user_word = user_cut({user_pattern_byte[{user_sel, 1'b1}], user_pattern_byte[{user_sel, 1'b0}]}, point);

	// pn source, reseeded on every restart
	sltp_pn u_pn (
		.clk(CLOCK),
		.srst(SRST),
		.load(restart),
		.step(step && is_pn),
		.mode(mode),
		.nbits(nbits),
		.word(pn_word)
	);

	// restart one cycle after any mode write or soft reset
	always @(posedge CLOCK) begin
		if (SRST) begin
			restart <= 1'b1;
		end else begin
			restart <= cfg_write || soft_reset;
		end
	end

	// sequence counters advance once per accepted word
	always @(posedge CLOCK) begin
		if (SRST || restart || !active) begin
			phase <= 1'b0;
			ramp <= 16'h0000;
			user_sel <= 2'h0;
			single_done <= 1'b0;
		end else if (step) begin
			phase <= ~phase;
			ramp <= (ramp + 16'h0001) & mask;
			user_sel <= user_sel + 2'h1;
			if (user_sel == 2'h3) begin
				single_done <= 1'b1;
			end
		end
	end

	// pattern word for this step at the insertion width
	always @* begin
		case (mode)
			`SLTP_MODE_CHECKER: pattern_word = (phase ? `SLTP_CHECK_ODD : `SLTP_CHECK_EVEN) & mask;
			`SLTP_MODE_TOGGLE: pattern_word = phase ? mask : 16'h0000;
			`SLTP_MODE_PN31, `SLTP_MODE_PN23, `SLTP_MODE_PN15,
			`SLTP_MODE_PN9, `SLTP_MODE_PN7: pattern_word = pn_word & mask;
			`SLTP_MODE_RAMP: pattern_word = ramp & mask;
			`SLTP_MODE_USER_REPEAT: pattern_word = user_word;
			`SLTP_MODE_USER_SINGLE: pattern_word = single_done ? 16'h0000 : user_word;
			default: pattern_word = 16'h0000;
		endcase
	end

	// fill side: pattern frame, or raw samples when no pattern is on
	always @* begin
		if (!active) begin
			fill_data = SAMPLE_DATA;
		end else if (nbits == `SLTP_WIDTH_SAMPLE) begin
			fill_data = {4{pattern_word}};
		end else begin
			fill_data = {48'h000000000000, pattern_word};
		end
	end

	// samples are drained and dropped while a pattern replaces them
	assign fill_valid = active ? !restart : SAMPLE_VALID;
	assign SAMPLE_READY = active ? 1'b1 : fill_ready;

	// two-entry buffer toward the link
	sltp_buf #(
		.WIDTH(66),
		.DEPTH(2)
	) u_buf (
		.clk(CLOCK),
		.srst(SRST),
		.in_data({point, fill_data}),
		.in_valid(fill_valid),
		.in_ready(fill_ready),
		.out_data(drain_word),
		.out_valid(OUT_VALID),
		.out_ready(OUT_READY)
	);

	assign OUT_DATA = drain_word[63:0];
	assign OUT_POINT = drain_word[65:64];

endmodule // sltp_gen

// ---- verification/sltp_gen_checker.sv ----
/*
 Assertions on the ports of the test pattern generator.
 Assumes it is bound to sltp_gen, which has one clock and a synchronous reset.
*/
`timescale 1ns/100ps

module sltp_gen_checker (
	input wire CLOCK,
	input wire SRST,
	input wire REG_WRITE,
	input wire [11:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire [63:0] OUT_DATA,
	input wire [1:0] OUT_POINT,
	input wire OUT_VALID,
	input wire OUT_READY,
	input wire TPL_SAMPLE_TEST,
	input wire [2:0] LINK_TEST_MODE,
	input wire LINK_SYNC_REQUEST_INPUT_OFF
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SRST);
	reg [5:0] sel = 6'h00;
	reg [1:0] nhs = 2'h0;
	wire wr_sel = REG_WRITE && REG_ADDR == 12'h573;
	wire wr_rst = REG_WRITE && REG_ADDR == 12'h000 && REG_WDATA == 8'h81;
	wire set = nhs == 2'h2;
	wire tk = OUT_VALID && OUT_READY;
	wire [15:0] msk = OUT_POINT == 2'h1 ? 16'h03ff : OUT_POINT == 2'h2 ? 16'h00ff : 16'hffff;

	// mode shadow; set once two older buffered words have left
	always @(posedge CLOCK) begin
		if (SRST || wr_rst) sel <= 6'h00;
		else if (wr_sel) sel <= REG_WDATA[5:0];
		if (SRST || wr_rst || wr_sel) nhs <= 2'h0;
		else if (tk && !set) nhs <= nhs + 2'h1;
	end

	AST_STALL_HOLD: assert property (OUT_VALID && !OUT_READY && !wr_rst |=> OUT_VALID && $stable(OUT_DATA))
		else $error("word changed while stalled");
	// register lands on the write edge, the output copy one edge later
	AST_TPL_FLAG: assert property (REG_WRITE && REG_ADDR == 12'h571 |=> ##1
		TPL_SAMPLE_TEST == $past(REG_WDATA[5], 2)) else $error("sample test flag wrong");
	AST_LL_MODE: assert property (REG_WRITE && REG_ADDR == 12'h574 |=> ##1
		LINK_TEST_MODE == $past(REG_WDATA[2:0], 2)) else $error("link layer mode wrong");
	AST_SYNC_OFF: assert property (REG_WRITE && REG_ADDR == 12'h572 |=> ##1
		LINK_SYNC_REQUEST_INPUT_OFF == ($past(REG_WDATA, 2) == 8'hc0)) else $error("sync disable wrong");
	AST_LANES: assert property (set && sel[3:0] != 4'h0 && OUT_VALID && OUT_POINT == 2'h0 |->
		OUT_DATA[63:16] == {3{OUT_DATA[15:0]}}) else $error("lanes differ");
	AST_PAD_PHY: assert property (OUT_VALID && OUT_POINT == 2'h1 |-> OUT_DATA[63:10] == 54'h0)
		else $error("10-bit word not padded");
	AST_PAD_SCR: assert property (OUT_VALID && OUT_POINT == 2'h2 |-> OUT_DATA[63:8] == 56'h0)
		else $error("8-bit word not padded");
	AST_RAMP: assert property (set && sel[3:0] == 4'h8 && tk ##1 set && OUT_VALID |->
		OUT_DATA[15:0] == (($past(OUT_DATA[15:0]) + 16'h1) & msk)) else $error("ramp step wrong");
	AST_CHECKER: assert property (set && sel[3:0] == 4'h1 && tk ##1 set && OUT_VALID |->
		OUT_DATA[15:0] == (~$past(OUT_DATA[15:0]) & msk)) else $error("checkerboard wrong");

	cover property (set && sel[3:0] == 4'h8 && tk && OUT_DATA[7:0] == 8'hff);
	cover property (OUT_VALID && !OUT_READY ##1 OUT_VALID && !OUT_READY);
	cover property (tk && OUT_POINT == 2'h2 && sel[3:0] == 4'hf);
endmodule // sltp_gen_checker

bind sltp_gen sltp_gen_checker chk_i (.CLOCK(CLOCK), .SRST(SRST), .REG_WRITE(REG_WRITE), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .OUT_DATA(OUT_DATA), .OUT_POINT(OUT_POINT), .OUT_VALID(OUT_VALID),
	.OUT_READY(OUT_READY), .TPL_SAMPLE_TEST(TPL_SAMPLE_TEST), .LINK_TEST_MODE(LINK_TEST_MODE),
	.LINK_SYNC_REQUEST_INPUT_OFF(LINK_SYNC_REQUEST_INPUT_OFF));

// ---- verification/sltp_sink.sv ----
/*
 Receiver model for the pattern output: takes words with random stalls.
 Assumes one clock shared with the generator.
*/
`timescale 1ns/100ps

module sltp_sink (
	input wire clk,
	input wire srst,
	input wire hold,
	output reg ready
);
	integer seed = 32'ha030;
	initial ready = 1'b0;
	// ready moves just after the rising edge; hold stalls it fully
	always @(posedge clk) begin
		ready <= !srst && !hold && ($random(seed) % 4 != 0);
	end
endmodule // sltp_sink

// ---- verification/sltp_gen_bench.sv ----
/*
 Self-checking bench for the test pattern generator.
 Assumes sltp_gen, the receiver model sltp_sink and the bound checker.
*/
`timescale 1ns/100ps
`include "sltp_defs.vh"

module sltp_gen_bench;
	reg CLOCK = 1'b0;
	reg SRST = 1'b1;
	reg REG_WRITE = 1'b0;
	reg [11:0] REG_ADDR = 12'h000;
	reg [7:0] REG_WDATA = 8'h00;
	reg [63:0] SAMPLE_DATA = 64'h0;
	reg SAMPLE_VALID = 1'b0;
	reg hold = 1'b0;
	reg took = 1'b0;
	wire [7:0] REG_RDATA;
	wire SAMPLE_READY;
	wire [63:0] OUT_DATA;
	wire [1:0] OUT_POINT;
	wire OUT_VALID;
	wire OUT_READY;
	wire TPL_SAMPLE_TEST;
	wire [2:0] LINK_TEST_MODE;
	wire LINK_SYNC_REQUEST_INPUT_OFF;
	integer seed = 32'ha030;
	integer n_checks = 0, n_mismatch = 0, nrx = 0, k = 0, skip = 0, i, p, c;
	reg [5:0] bm = 6'h00;
	reg [30:0] pn_s = 31'h0;
	reg [7:0] ub [0:7];
	reg [63:0] q [$];
	reg [3:0] cm [0:9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'he, 4'hf};

	always #5 CLOCK = ~CLOCK;

	sltp_gen dut (.CLOCK(CLOCK), .SRST(SRST), .REG_WRITE(REG_WRITE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_READY(SAMPLE_READY),
		.OUT_DATA(OUT_DATA), .OUT_POINT(OUT_POINT), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
		.TPL_SAMPLE_TEST(TPL_SAMPLE_TEST), .LINK_TEST_MODE(LINK_TEST_MODE),
		.LINK_SYNC_REQUEST_INPUT_OFF(LINK_SYNC_REQUEST_INPUT_OFF));
	sltp_sink rx_model (.clk(CLOCK), .srst(SRST), .hold(hold), .ready(OUT_READY));

	// compare, count and report
	task chk(input [63:0] g, input [63:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t got %h exp %h", $time, g, e);
			end
		end
	endtask

	task conclude;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_mismatch);
			if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
			else $display("== FAILED ==");
			$finish;
		end
	endtask

	// register port: one-cycle write strobe, read data one cycle after the address
	task wr(input [11:0] a, input [7:0] d);
		begin
			REG_ADDR = a;
			REG_WDATA = d;
			REG_WRITE = 1'b1;
			@(negedge CLOCK);
			REG_WRITE = 1'b0;
		end
	endtask

	task rd(input [11:0] a, input [7:0] e);
		begin
			REG_ADDR = a;
			@(negedge CLOCK);
			chk({56'h0, REG_RDATA}, {56'h0, e});
		end
	endtask

	// wait for n output words under a bounded count
	task run(input integer n);
		integer j;
		begin
			nrx = 0;
			for (j = 0; j < 8 * n && nrx < n; j = j + 1) @(negedge CLOCK);
			chk({63'h0, nrx >= n}, 64'h1);
		end
	endtask

	// stall the receiver so the buffer is full, then write; two old pattern words are skipped, old samples are checked
	task set_mode(input [11:0] a, input [7:0] v);
		begin
			hold = 1'b1;
			repeat (6) @(negedge CLOCK);
			wr(a, v);
			skip = bm == 6'h00 ? 0 : 2;
			bm = a == 12'h000 ? 6'h00 : v[5:0];
			k = 0;
			case (v[3:0])
				4'h3: pn_s = `SLTP_SEED_PN31;
				4'h4: pn_s = `SLTP_SEED_PN23;
				4'h5: pn_s = `SLTP_SEED_PN15;
				4'h6: pn_s = `SLTP_SEED_PN9;
				default: pn_s = `SLTP_SEED_PN7;
			endcase
			hold = 1'b0;
		end
	endtask

	function [15:0] pn_next(input integer n, input integer t, input integer nb);
		reg b;
		integer j;
		begin
			pn_next = 16'h0;
			for (j = 0; j < nb; j = j + 1) begin
				b = pn_s[n - 1] ^ pn_s[t - 1];
				pn_s = ((pn_s << 1) | b) & ((31'h1 << n) - 31'h1);
				pn_next = {pn_next[14:0], b};
			end
		end
	endfunction

	function [63:0] expw(input integer x);
		reg [15:0] w;
		integer nb;
		begin
			nb = bm[5:4] == 2'h1 ? 10 : bm[5:4] == 2'h2 ? 8 : 16;
			case (bm[3:0])
				4'h1: w = x[0] ? 16'haaaa : 16'h5555;
				4'h2: w = x[0] ? 16'hffff : 16'h0000;
				4'h3: w = pn_next(31, 28, nb);
				4'h4: w = pn_next(23, 18, nb);
				4'h5: w = pn_next(15, 14, nb);
				4'h6: w = pn_next(9, 5, nb);
				4'h7: w = pn_next(7, 6, nb);
				4'h8: w = x[15:0];
				4'he, 4'hf: w = (bm[3:0] == 4'he || x < 4) ? {ub[2 * (x % 4) + 1], ub[2 * (x % 4)]} : 16'h0;
				default: w = 16'h0;
			endcase
			if (bm[3:0] >= 4'he) w = w >> (nb == 8 ? 9 : 16 - nb);
			w = w & (16'hffff >> (16 - nb));
			expw = nb == 16 ? {4{w}} : {48'h0, w};
		end
	endfunction

	// sample driver holds until taken; both sides judged settled after the falling edge
	always @(negedge CLOCK) begin
		if (took || !SAMPLE_VALID) begin
			SAMPLE_VALID <= $random(seed) % 2 != 0;
			SAMPLE_DATA <= {$random(seed), $random(seed)};
		end
		#2;
		took = SAMPLE_VALID && SAMPLE_READY && !SRST;
		if (took && bm == 6'h00) q.push_back(SAMPLE_DATA);
		if (OUT_VALID && OUT_READY && !SRST) begin
			nrx = nrx + 1;
			if (skip > 0) skip = skip - 1;
			else if (q.size() > 0) chk(OUT_DATA, q.pop_front());
			else begin
				chk(OUT_DATA, expw(k));
				k = k + 1;
			end
		end
	end

	// watchdog well beyond the roughly 5000 cycles the tests need
	initial begin
		#300000;
		n_mismatch = n_mismatch + 1;
		conclude;
	end

	// main sequence
	initial begin
		repeat (3) @(negedge CLOCK);
		SRST = 1'b0;
		rd(`SLTP_OFF_LINK_CTRL_A, 8'h00);
		rd(`SLTP_OFF_LINK_CTRL_B, 8'h00);
		rd(`SLTP_OFF_IF_TEST, 8'h00);
		rd(12'h575, 8'h00);
		wr(`SLTP_OFF_LINK_CTRL_A, 8'h20);
		@(negedge CLOCK);
		chk({63'h0, TPL_SAMPLE_TEST}, 64'h1);
		run(64);
		$display("raw samples done");
		wr(`SLTP_OFF_LINK_CTRL_B, `SLTP_SYNC_OFF_VALUE);
		c = $random(seed);
		wr(`SLTP_OFF_LL_TEST, c[7:0]);
		@(negedge CLOCK);
		chk({63'h0, LINK_SYNC_REQUEST_INPUT_OFF}, 64'h1);
		chk({61'h0, LINK_TEST_MODE}, {61'h0, c[2:0]});
		rd(`SLTP_OFF_LL_TEST, {5'h0, c[2:0]});
		for (i = 0; i < 8; i = i + 1) begin
			ub[i] = $random(seed);
			wr(`SLTP_OFF_USER_FIRST + i[11:0], ub[i]);
			rd(`SLTP_OFF_USER_FIRST + i[11:0], ub[i]);
		end
		for (p = 0; p < 3; p = p + 1) begin
			for (c = 0; c < 10; c = c + 1) begin
				set_mode(`SLTP_OFF_IF_TEST, {2'h0, p[1:0], cm[c]});
				run(cm[c] == 4'h8 ? (p == 0 ? 300 : 1100) : 24);
				$display("pattern %h done", bm);
			end
		end
		rd(`SLTP_OFF_IF_TEST, 8'h2f);
		set_mode(`SLTP_OFF_SOFT_RESET, `SLTP_SOFT_RESET_CMD);
		rd(`SLTP_OFF_IF_TEST, 8'h00);
		rd(`SLTP_OFF_USER_FIRST, 8'h00);
		chk({63'h0, TPL_SAMPLE_TEST}, 64'h0);
		run(32);
		$display("soft reset done");
		conclude;
	end
endmodule // sltp_gen_bench
